// [verilog/pae_alarm.sv]
// Process alarm evaluator: register file, comparison and alarm outputs.
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/10ps
`include "pae_defs.svh"

module pae_alarm
	import pae_pkg::*;
#(
	parameter int N_CH = 3,
	parameter bit RSP_FITTED = 1'b1,
	parameter bit HEATER_OPT = 1'b1,
	parameter int SEC_CYCLES = `PAE_SEC_NS / `PAE_CLK_NS
) (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic [7:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_we,
	input wire logic i_re,
	output logic [15:0] o_rdata,
	input wire logic i_sample,
	input wire logic [15:0] i_process_value,
	input wire logic [15:0] i_remote_set_point,
	input wire logic i_loop_break_alarm,
	input wire logic [N_CH-1:0] i_change_rate_alarm,
	input wire logic i_heater_burnout,
	input wire logic i_relay_failure,
	input wire logic i_heater_overcurrent,
	output logic [N_CH-1:0] o_alarm
);

	// ****************************************************************
	// Helper functions
	// ****************************************************************
	function automatic logic signed [17:0] sx(input logic [15:0] v);
		return {{2{v[15]}}, v};
	endfunction

	function automatic logic above(input logic signed [17:0] v,
		input logic signed [17:0] thr, input logic signed [17:0] hys,
		input logic cur);
		return cur ? (v > thr - hys) : (v > thr);
	endfunction

	function automatic logic below(input logic signed [17:0] v,
		input logic signed [17:0] thr, input logic signed [17:0] hys,
		input logic cur);
		return cur ? (v < thr + hys) : (v < thr);
	endfunction

	function automatic logic is_standby(input logic [3:0] t);
		return t == PAE_T_DEV_HL_SB || t == PAE_T_DEV_HI_SB ||
			t == PAE_T_DEV_LO_SB || t == PAE_T_ABS_HI_SB ||
			t == PAE_T_ABS_LO_SB;
	endfunction

	function automatic logic type_ok(input int ch, input logic [3:0] t);
		if (t == PAE_T_LOOP_BREAK && ch != 0) begin
			return 1'b0;
		end
		if ((t == PAE_T_RSP_HI || t == PAE_T_RSP_LO) && !RSP_FITTED) begin
			return 1'b0;
		end
		return 1'b1;
	endfunction

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [3:0] type_q [N_CH];
	logic [15:0] value_q [N_CH];
	logic [15:0] upper_q [N_CH];
	logic [15:0] lower_q [N_CH];
	logic [15:0] hyst_q [N_CH];
	logic [9:0] on_dly_q [N_CH];
	logic [9:0] off_dly_q [N_CH];
	logic [15:0] set_point_q;
	logic [15:0] rdata_q;
	logic [N_CH-1:0] raw_q;
	logic [N_CH-1:0] armed_q;
	logic [N_CH-1:0] cond_d;
	logic [N_CH-1:0] gated;
	logic [N_CH-1:0] delayed;
	logic [N_CH-1:0] alarm_q;
	logic [2:0] fault_meta_q;
	logic [2:0] fault_q;
	logic [31:0] sec_cnt_q;
	logic tick_q;
	logic [2:0] field;
	logic sel_ch;
	int ch_idx;

	assign field = i_addr[2:0];
	assign ch_idx = int'(i_addr[7:`PAE_CH_SHIFT]);
	assign sel_ch = (ch_idx < N_CH);

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			for (int i = 0; i < N_CH; i++) begin
				type_q[i] <= `PAE_TYPE_RST;
				value_q[i] <= `PAE_VALUE_RST;
				upper_q[i] <= `PAE_VALUE_RST;
				lower_q[i] <= `PAE_VALUE_RST;
				hyst_q[i] <= `PAE_HYST_RST;
				on_dly_q[i] <= `PAE_DLY_RST;
				off_dly_q[i] <= `PAE_DLY_RST;
			end
			set_point_q <= `PAE_VALUE_RST;
		end else if (i_we) begin
			if (i_addr == `PAE_G_SET_POINT) begin
				set_point_q <= i_wdata;
			end
			for (int i = 0; i < N_CH; i++) begin
				if (sel_ch && ch_idx == i) begin
					case (field)
						`PAE_F_TYPE: begin
							if (type_ok(i, i_wdata[3:0])) begin
								type_q[i] <= i_wdata[3:0];
							end
						end
						`PAE_F_VALUE: begin
							value_q[i] <= i_wdata;
						end
						`PAE_F_UPPER: begin
							upper_q[i] <= i_wdata;
						end
						`PAE_F_LOWER: begin
							lower_q[i] <= i_wdata;
						end
						`PAE_F_HYST: begin
							hyst_q[i] <= i_wdata;
						end
						`PAE_F_ON_DLY: begin
							on_dly_q[i] <= (i_wdata[9:0] > `PAE_DLY_MAX)
								? `PAE_DLY_MAX : i_wdata[9:0];
						end
						`PAE_F_OFF_DLY: begin
							off_dly_q[i] <= (i_wdata[9:0] > `PAE_DLY_MAX)
								? `PAE_DLY_MAX : i_wdata[9:0];
						end
						default: begin
						end
					endcase
				end
			end
		end
	end

	// ****************************************************************
	// Read data, valid the cycle after the read strobe
	// ****************************************************************
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			rdata_q <= 16'h0000;
		end else if (i_re) begin
			rdata_q <= 16'h0000;
			if (i_addr == `PAE_G_SET_POINT) begin
				rdata_q <= set_point_q;
			end else if (i_addr == `PAE_G_FAULTS) begin
				rdata_q <= {13'h0000, fault_q};
			end
			for (int i = 0; i < N_CH; i++) begin
				if (sel_ch && ch_idx == i) begin
					case (field)
						`PAE_F_TYPE: rdata_q <= {12'h000, type_q[i]};
						`PAE_F_VALUE: rdata_q <= value_q[i];
						`PAE_F_UPPER: rdata_q <= upper_q[i];
						`PAE_F_LOWER: rdata_q <= lower_q[i];
						`PAE_F_HYST: rdata_q <= hyst_q[i];
						`PAE_F_ON_DLY: rdata_q <= {6'h00, on_dly_q[i]};
						`PAE_F_OFF_DLY: rdata_q <= {6'h00, off_dly_q[i]};
						`PAE_F_STATUS: begin
							rdata_q <= {12'h000, alarm_q[i], armed_q[i],
								gated[i], raw_q[i]};
						end
						default: rdata_q <= 16'h0000;
					endcase
				end
			end
		end
	end

	assign o_rdata = rdata_q;

	// ****************************************************************
	// Heater fault inputs come from pins and are synchronised first
	// ****************************************************************
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			fault_meta_q <= 3'h0;
			fault_q <= 3'h0;
		end else begin
			fault_meta_q <= {i_heater_overcurrent, i_relay_failure,
				i_heater_burnout};
			fault_q <= fault_meta_q;
		end
	end

	// ****************************************************************
	// One second tick shared by all delay counters
	// ****************************************************************
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			sec_cnt_q <= 32'h0000_0000;
			tick_q <= 1'b0;
		end else if (sec_cnt_q >= 32'(SEC_CYCLES - 1)) begin
			sec_cnt_q <= 32'h0000_0000;
			tick_q <= 1'b1;
		end else begin
			sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
			tick_q <= 1'b0;
		end
	end

	// ****************************************************************
	// Comparison per channel
	// ****************************************************************
	always_comb begin
		logic signed [17:0] pv;
		logic signed [17:0] sp;
		logic signed [17:0] x;
		logic signed [17:0] hi;
		logic signed [17:0] lo;
		logic signed [17:0] hy;
		logic cur;
		pv = sx(i_process_value);
		sp = sx(set_point_q);
		x = 18'sh00000;
		hi = 18'sh00000;
		lo = 18'sh00000;
		hy = 18'sh00000;
		cur = 1'b0;
		for (int i = 0; i < N_CH; i++) begin
			x = sx(value_q[i]);
			hi = sp + sx(upper_q[i]);
			lo = sp - sx(lower_q[i]);
			hy = sx(hyst_q[i]);
			cur = raw_q[i];
			case (type_q[i])
				PAE_T_OFF: cond_d[i] = 1'b0;
				PAE_T_DEV_HL: begin
					cond_d[i] = above(pv, hi, hy, cur) ||
						below(pv, lo, hy, cur);
				end
				PAE_T_DEV_HL_SB: begin
					// Overlapping bands would chatter, so the condition is forced off.
					cond_d[i] = (hi - hy > lo + hy) &&
						(above(pv, hi, hy, cur) ||
						below(pv, lo, hy, cur));
				end
				PAE_T_DEV_HI, PAE_T_DEV_HI_SB: begin
					cond_d[i] = above(pv, sp + x, hy, cur);
				end
				PAE_T_DEV_LO, PAE_T_DEV_LO_SB: begin
					cond_d[i] = below(pv, sp - x, hy, cur);
				end
				PAE_T_RANGE: begin
					cond_d[i] = !above(pv, hi, hy, !cur) &&
						!below(pv, lo, hy, !cur);
				end
				PAE_T_ABS_HI, PAE_T_ABS_HI_SB: begin
					cond_d[i] = above(pv, x, hy, cur);
				end
				PAE_T_ABS_LO, PAE_T_ABS_LO_SB: begin
					cond_d[i] = below(pv, x, hy, cur);
				end
				PAE_T_LOOP_BREAK: begin
					cond_d[i] = (i == 0) && i_loop_break_alarm;
				end
				PAE_T_RATE: cond_d[i] = i_change_rate_alarm[i];
				PAE_T_RSP_HI: begin
					cond_d[i] = RSP_FITTED &&
						above(sx(i_remote_set_point), x, hy, cur);
				end
				PAE_T_RSP_LO: begin
					cond_d[i] = RSP_FITTED &&
						below(sx(i_remote_set_point), x, hy, cur);
				end
				default: cond_d[i] = 1'b0;
			endcase
		end
	end

	// ****************************************************************
	// Sample-rate state: raw result and standby arming
	// ****************************************************************
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			raw_q <= '0;
		end else if (i_sample) begin
			raw_q <= cond_d;
		end
	end

	// A new type restarts the standby sequence for that channel.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			armed_q <= '0;
		end else begin
			for (int i = 0; i < N_CH; i++) begin
				if (i_we && sel_ch && ch_idx == i && field == `PAE_F_TYPE) begin
					armed_q[i] <= 1'b0;
				end else if (i_sample && !cond_d[i]) begin
					armed_q[i] <= 1'b1;
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < N_CH; i++) begin
			gated[i] = raw_q[i] &&
				(!is_standby(type_q[i]) || armed_q[i]);
		end
	end

	// ****************************************************************
	// Delay shaping and outputs
	// ****************************************************************
	for (genvar g = 0; g < N_CH; g++) begin : g_dly
		pae_delay u_delay (
			.i_mclk(i_mclk),
			.i_rstn(i_rstn),
			.i_tick(tick_q),
			.i_cond(gated[g]),
			.i_on_dly(on_dly_q[g]),
			.i_off_dly(off_dly_q[g]),
			.o_out(delayed[g])
		);
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			alarm_q <= '0;
		end else begin
			alarm_q <= delayed;
			alarm_q[0] <= delayed[0] ||
				(HEATER_OPT && (|fault_q));
		end
	end

	assign o_alarm = alarm_q;

endmodule

// [verilog/pae_defs.svh]
// Constants for the process alarm evaluator: offsets, resets and timing.
`ifndef PAE_DEFS_SVH
`define PAE_DEFS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define PAE_CLK_NS 50
`define PAE_SEC_NS 1000000000
`define PAE_DLY_MAX 10'h3e7

// ****************************************************************
// Register map, per channel base is channel times eight
// ****************************************************************
`define PAE_CH_SHIFT 3
`define PAE_F_TYPE 3'h0
`define PAE_F_VALUE 3'h1
`define PAE_F_UPPER 3'h2
`define PAE_F_LOWER 3'h3
`define PAE_F_HYST 3'h4
`define PAE_F_ON_DLY 3'h5
`define PAE_F_OFF_DLY 3'h6
`define PAE_F_STATUS 3'h7
`define PAE_G_SET_POINT 8'h40
`define PAE_G_FAULTS 8'h41

// ****************************************************************
// Reset values
// ****************************************************************
`define PAE_TYPE_RST 4'h2
`define PAE_VALUE_RST 16'h0000
`define PAE_HYST_RST 16'h0001
`define PAE_DLY_RST 10'h000

`endif

// [verilog/pae_pkg.sv]
// Types shared by the process alarm evaluator modules.
package pae_pkg;

	typedef enum logic [3:0] {
		PAE_T_OFF = 4'h0,
		PAE_T_DEV_HL = 4'h1,
		PAE_T_DEV_HI = 4'h2,
		PAE_T_DEV_LO = 4'h3,
		PAE_T_RANGE = 4'h4,
		PAE_T_DEV_HL_SB = 4'h5,
		PAE_T_DEV_HI_SB = 4'h6,
		PAE_T_DEV_LO_SB = 4'h7,
		PAE_T_ABS_HI = 4'h8,
		PAE_T_ABS_LO = 4'h9,
		PAE_T_ABS_HI_SB = 4'ha,
		PAE_T_ABS_LO_SB = 4'hb,
		PAE_T_LOOP_BREAK = 4'hc,
		PAE_T_RATE = 4'hd,
		PAE_T_RSP_HI = 4'he,
		PAE_T_RSP_LO = 4'hf
	} pae_type_t;

	typedef enum logic [1:0] {
		PAE_D_OFF = 2'b00,
		PAE_D_ON_WAIT = 2'b01,
		PAE_D_ON = 2'b10,
		PAE_D_OFF_WAIT = 2'b11
	} pae_dly_t;

endpackage

// [verilog/pae_delay.sv]
// ON and OFF delay shaping of one alarm channel.
`timescale 1ns/10ps
`include "pae_defs.svh"

module pae_delay
	import pae_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_tick,
	input wire logic i_cond,
	input wire logic [9:0] i_on_dly,
	input wire logic [9:0] i_off_dly,
	output logic o_out
);

	pae_dly_t state_q;
	logic [9:0] cnt_q;
	logic out_q;

	// ****************************************************************
	// Delay state machine
	// ****************************************************************
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= PAE_D_OFF;
		end else begin
			case (state_q)
				PAE_D_OFF: begin
					if (i_cond) begin
						state_q <= (i_on_dly == `PAE_DLY_RST) ? PAE_D_ON
							: PAE_D_ON_WAIT;
					end
				end
				PAE_D_ON_WAIT: begin
					if (!i_cond) begin
						state_q <= PAE_D_OFF;
					end else if (cnt_q >= i_on_dly) begin
						state_q <= PAE_D_ON;
					end
				end
				PAE_D_ON: begin
					if (!i_cond) begin
						state_q <= (i_off_dly == `PAE_DLY_RST) ? PAE_D_OFF
							: PAE_D_OFF_WAIT;
					end
				end
				PAE_D_OFF_WAIT: begin
					if (i_cond) begin
						state_q <= PAE_D_ON;
					end else if (cnt_q >= i_off_dly) begin
						state_q <= PAE_D_OFF;
					end
				end
				default: begin
					state_q <= PAE_D_OFF;
				end
			endcase
		end
	end

	// Seconds are counted on the shared tick, so a delay may run up to
	// one second short; a finer tick would cost a wider counter.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_q <= `PAE_DLY_RST;
		end else if (state_q == PAE_D_ON_WAIT ||
			state_q == PAE_D_OFF_WAIT) begin
			if (i_tick && cnt_q != `PAE_DLY_MAX) begin
				cnt_q <= cnt_q + 10'h001;
			end
		end else begin
			cnt_q <= `PAE_DLY_RST;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			out_q <= 1'b0;
		end else begin
			out_q <= (state_q == PAE_D_ON) || (state_q == PAE_D_OFF_WAIT);
		end
	end

	assign o_out = out_q;

endmodule

// [sim/pae_alarm_monitor.sv]
// Assertion checker for the process alarm evaluator ports.
`timescale 1ns/10ps
module pae_alarm_monitor
	import pae_pkg::*;
#(
	parameter int N_CH = 3
) (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic [7:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_we,
	input wire logic i_re,
	input wire logic [15:0] o_rdata,
	input wire logic i_sample,
	input wire logic [15:0] i_process_value,
	input wire logic [15:0] i_remote_set_point,
	input wire logic i_loop_break_alarm,
	input wire logic [N_CH-1:0] i_change_rate_alarm,
	input wire logic i_heater_burnout,
	input wire logic i_relay_failure,
	input wire logic i_heater_overcurrent,
	input wire logic [N_CH-1:0] o_alarm
);
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rstn);

	reset_quiet_a: assert property (
		$rose(i_rstn) |-> o_alarm == '0 && o_rdata == 16'h0000)
		else $error("outputs not idle after reset");
	// Two sync stages and the output register give three cycles of latency, so the fourth sampled cycle sees it.
	heater_or_a: assert property (
		(i_heater_burnout || i_relay_failure || i_heater_overcurrent) [*4]
		|-> o_alarm[0])
		else $error("heater fault missing on alarm one");
	rd_hold_a: assert property (
		!$past(i_re) |-> $stable(o_rdata))
		else $error("read data moved without a read");
	type_echo_a: assert property (
		i_we && i_addr == 8'h10 && i_wdata[3:0] != 4'hc
		##1 i_re && i_addr == 8'h10 |=> o_rdata[3:0] == $past(i_wdata[3:0], 2))
		else $error("type code not held");
	sp_echo_a: assert property (
		i_we && i_addr == 8'h40 ##1 i_re && i_addr == 8'h40
		|=> o_rdata == $past(i_wdata, 2))
		else $error("set point not held");
	lba_chan_a: assert property (
		$past(i_re) && ($past(i_addr) == 8'h08 || $past(i_addr) == 8'h10)
		|-> o_rdata[3:0] != 4'hc)
		else $error("loop break type on wrong channel");
	delay_clamp_a: assert property (
		$past(i_re) && $past(i_addr) < 8'h40
		&& ($past(i_addr[2:0]) == 3'h5 || $past(i_addr[2:0]) == 3'h6)
		|-> o_rdata <= 16'h03e7)
		else $error("delay above ceiling");
	unmapped_a: assert property (
		$past(i_re) && $past(i_addr) > 8'h41 |-> o_rdata == 16'h0000)
		else $error("unmapped read not zero");

	cover property ($rose(o_alarm[0]));
	cover property ($rose(o_alarm[1]));
	cover property ($fell(o_alarm[2]));
endmodule

bind pae_alarm pae_alarm_monitor #(.N_CH(N_CH)) u_mon (
	.i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_we(i_we), .i_re(i_re), .o_rdata(o_rdata), .i_sample(i_sample),
	.i_process_value(i_process_value),
	.i_remote_set_point(i_remote_set_point),
	.i_loop_break_alarm(i_loop_break_alarm),
	.i_change_rate_alarm(i_change_rate_alarm),
	.i_heater_burnout(i_heater_burnout), .i_relay_failure(i_relay_failure),
	.i_heater_overcurrent(i_heater_overcurrent), .o_alarm(o_alarm)
);

// [sim/pae_plant.sv]
// Model of the measured inputs and heater fault pins of the evaluator.
`timescale 1ns/10ps
module pae_plant (
	output logic [15:0] o_pv,
	output logic [15:0] o_rsp,
	output logic o_lba,
	output logic [2:0] o_rate,
	output logic [2:0] o_flt
);
	// Idle inactive, so nothing alarms before it is asked for.
	initial begin
		o_pv = 16'h0000;
		o_rsp = 16'h0000;
		o_lba = 1'b0;
		o_rate = 3'h0;
		o_flt = 3'h0;
	end
	// Callers enter just after a rising edge, keeping changes off the edge.
	task automatic apply(input logic [15:0] pv, input logic [15:0] rsp);
		o_pv <= pv;
		o_rsp <= rsp;
	endtask
	task automatic pins(input logic loop_break_alarm, input logic [2:0] rate,
		input logic [2:0] flt);
		o_lba <= loop_break_alarm;
		o_rate <= rate;
		o_flt <= flt;
	endtask
endmodule

// [sim/tb_top.sv]
// Self-checking testbench for the process alarm evaluator.
`timescale 1ns/10ps
module tb_top;
	import pae_pkg::*;
	logic i_mclk = 1'b0;
	logic i_rstn = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [15:0] i_wdata = 16'h0000;
	logic i_we = 1'b0;
	logic i_re = 1'b0;
	logic i_sample = 1'b0;
	logic [15:0] o_rdata, pv, rsp;
	logic loop_break_alarm;
	logic [2:0] rate, flt, o_alarm;
	logic [15:0] rdata_norsp;
	logic [2:0] alarm_norsp;
	int failures = 0;
	int samples_checked = 0;
	int n;
	logic [15:0] tab [22][4];

	always #25 i_mclk = ~i_mclk;

	pae_plant u_plant (.o_pv(pv), .o_rsp(rsp), .o_lba(loop_break_alarm), .o_rate(rate),
		.o_flt(flt));
	// A four cycle second keeps the delay counts short.
	pae_alarm #(.SEC_CYCLES(4)) u_dut (
		.i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_we(i_we), .i_re(i_re), .o_rdata(o_rdata), .i_sample(i_sample),
		.i_process_value(pv), .i_remote_set_point(rsp),
		.i_loop_break_alarm(loop_break_alarm), .i_change_rate_alarm(rate),
		.i_heater_burnout(flt[0]), .i_relay_failure(flt[1]),
		.i_heater_overcurrent(flt[2]), .o_alarm(o_alarm)
	);
	// A copy without the remote set point input shows the refusal.
	pae_alarm #(.SEC_CYCLES(4), .RSP_FITTED(1'b0)) u_dut_norsp (
		.i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_we(i_we), .i_re(i_re), .o_rdata(rdata_norsp),
		.i_sample(i_sample), .i_process_value(pv),
		.i_remote_set_point(rsp), .i_loop_break_alarm(loop_break_alarm),
		.i_change_rate_alarm(rate), .i_heater_burnout(flt[0]),
		.i_relay_failure(flt[1]), .i_heater_overcurrent(flt[2]),
		.o_alarm(alarm_norsp)
	);

	// ****************************************************************
	// Tasks, all but chk entered just after a rising edge
	// ****************************************************************
	task automatic give_verdict();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		i_we <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_we <= 1'b0;
		@(posedge i_mclk);
	endtask
	task automatic wrrd(input logic [7:0] a, input logic [15:0] d,
		input logic [15:0] e);
		i_we <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_we <= 1'b0;
		rd(a, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		i_re <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_re <= 1'b0;
		@(negedge i_mclk);
		chk(o_rdata, e);
		@(posedge i_mclk);
	endtask
	task automatic drive(input logic [15:0] p);
		u_plant.apply(p, p);
		i_sample <= 1'b1;
		@(posedge i_mclk);
		i_sample <= 1'b0;
		repeat (6) @(posedge i_mclk);
	endtask
	task automatic ev(input int ch, input logic [15:0] p,
		input logic [15:0] e);
		drive(p);
		@(negedge i_mclk);
		chk({15'h0000, o_alarm[ch]}, e);
		@(posedge i_mclk);
	endtask
	task automatic wait_al(input int ch, input logic v, input int lim);
		n = 0;
		while (o_alarm[ch] !== v && n < lim) begin
			@(posedge i_mclk);
			n++;
		end
		if (o_alarm[ch] !== v) begin
			failures++;
			give_verdict();
		end
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		// Rows: type, settling value, tested value, expected alarm.
		tab = '{'{16'h0, 16'h64, 16'h1f4, 16'h0}, '{16'h1, 16'h64, 16'h7d, 16'h1},
			'{16'h1, 16'h64, 16'h41, 16'h1}, '{16'h2, 16'h64, 16'h6f, 16'h1},
			'{16'h2, 16'h64, 16'h6e, 16'h0}, '{16'h3, 16'h64, 16'h59, 16'h1},
			'{16'h4, 16'h82, 16'h64, 16'h1}, '{16'h4, 16'h82, 16'h45, 16'h0},
			'{16'h5, 16'h64, 16'h7d, 16'h1}, '{16'h6, 16'h64, 16'h6f, 16'h1},
			'{16'h6, 16'h6f, 16'h6f, 16'h0}, '{16'h7, 16'h64, 16'h59, 16'h1},
			'{16'h8, 16'h0, 16'hb, 16'h1}, '{16'h8, 16'h0, 16'ha, 16'h0},
			'{16'h9, 16'h64, 16'h9, 16'h1}, '{16'ha, 16'h0, 16'hb, 16'h1},
			'{16'ha, 16'hb, 16'hb, 16'h0}, '{16'hb, 16'h64, 16'h9, 16'h1},
			'{16'hd, 16'h0, 16'h0, 16'h1}, '{16'he, 16'h0, 16'hb, 16'h1},
			'{16'hf, 16'h64, 16'h9, 16'h1}, '{16'hf, 16'h64, 16'h14, 16'h0}};
		repeat (20) @(posedge i_mclk);
		i_rstn <= 1'b1;
		@(posedge i_mclk);
		for (int c = 0; c < 3; c++) begin
			rd(8'(c * 8), 16'h0002);
		end
		rd(8'h04, 16'h0001);
		wr(8'h00, 16'h0000);
		drive(16'h0000);
		for (int i = 0; i < 3; i++) begin
			u_plant.pins(1'b0, 3'h0, 3'(1 << i));
			wait_al(0, 1'b1, 8);
			rd(8'h41, 16'(1 << i));
			u_plant.pins(1'b0, 3'h0, 3'h0);
			wait_al(0, 1'b0, 8);
		end
		wrrd(8'h40, 16'h0064, 16'h0064);
		wr(8'h09, 16'h000a);
		wr(8'h0a, 16'h0014);
		wr(8'h0b, 16'h001e);
		for (int i = 0; i < 22; i++) begin
			wr(8'h08, tab[i][0]);
			u_plant.pins(1'b0, {1'b0, tab[i][0] == 16'hd, 1'b0}, 3'h0);
			drive(tab[i][1]);
			ev(1, tab[i][2], tab[i][3]);
			// The row above also
			// and through the standby rows.
		end
		wr(8'h08, 16'h0008);
		wr(8'h0c, 16'h0005);
		ev(1, 16'h000b, 16'h0001);
		ev(1, 16'h0006, 16'h0001);
		ev(1, 16'h0005, 16'h0000);
		wr(8'h0c, 16'h0001);
		wr(8'h0a, 16'h0000);
		wr(8'h0b, 16'h0000);
		wr(8'h08, 16'h0005);
		drive(16'h0064);
		ev(1, 16'h00c8, 16'h0000);
		rd(8'h0f, 16'h0004);
		wr(8'h08, 16'h000c);
		rd(8'h08, 16'h0005);
		wrrd(8'h10, 16'h0008, 16'h0008);
		wr(8'h11, 16'h000a);
		drive(16'h0000);
		wr(8'h15, 16'h0002);
		wr(8'h16, 16'h0002);
		ev(2, 16'h000b, 16'h0000);
		wait_al(2, 1'b1, 16);
		chk({15'h0000, n > 1}, 16'h0001);
		ev(2, 16'h0000, 16'h0001);
		wait_al(2, 1'b0, 12);
		wr(8'h05, 16'h03ff);
		rd(8'h05, 16'h03e7);
		wr(8'h06, 16'h03e7);
		rd(8'h06, 16'h03e7);
		wr(8'h05, 16'h0000);
		wr(8'h06, 16'h0000);
		wr(8'h00, 16'h000c);
		rd(8'h00, 16'h000c);
		u_plant.pins(1'b1, 3'h0, 3'h0);
		ev(0, 16'h0000, 16'h0001);
		chk({15'h0000, alarm_norsp[0]}, 16'h0001);
		wr(8'h00, 16'h000e);
		rd(8'h00, 16'h000e);
		chk(rdata_norsp, 16'h000c);
		wr(8'h50, 16'hffff);
		rd(8'h50, 16'h0000);
		rd(8'h08, 16'h0005);
		give_verdict();
	end
endmodule
